// [hw/mwfd_pkg.sv]
// shared constants and carriers for the microword field decoder
package mwfd_pkg;
  // microword field positions, bit 0 is the leftmost bit of the word
  localparam int MW_W       = 108;  // microword width
  localparam int F_J        = 0;    // next address base, 12 bits
  localparam int F_ADFN     = 12;   // adder function, 3 bits
  localparam int F_LEFT_SOURCE_SELECT     = 15;   // left source, 3 bits
  localparam int F_DEST     = 18;   // destination, 3 bits
  localparam int F_A        = 21;   // register file A address, 4 bits
  localparam int F_B        = 25;   // register file B address, 4 bits
  localparam int F_RIGHT_SOURCE_SELECT     = 29;   // right source, 3 bits
  localparam int F_RSEL     = 32;   // 1 when a right source is coded
  localparam int F_RAMSRC   = 36;   // ram file address source, 3 bits
  localparam int F_DBUS     = 40;   // d bus mixer source, 2 bits
  localparam int F_DBM      = 42;   // bus mux input, 3 bits
  localparam int F_CLKL     = 45;
  localparam int F_LEFT_PARITY_VALID_GEN     = 46;
  localparam int F_CHKL     = 47;
  localparam int F_CLKR     = 48;
  localparam int F_RIGHT_PARITY_VALID_GEN     = 49;
  localparam int F_CHKR     = 50;
  localparam int F_SPEC     = 51;   // special, 6 bits
  localparam int F_DISP     = 57;   // dispatch, 6 bits
  localparam int F_SKIP     = 63;   // skip, 6 bits
  localparam int F_TIME     = 70;   // extra ticks, 2 bits
  localparam int F_CRY      = 72;
  localparam int F_LDSC     = 73;
  localparam int F_LDFE     = 74;
  localparam int F_RAMWR    = 75;
  localparam int F_MEM      = 76;
  localparam int F_FAST     = 79;
  localparam int F_CALL     = 80;
  localparam int F_NUM      = 90;   // number field, 18 bits
  // codes
  localparam logic [2:0] DEST_INV = 3'h2;  // middle destination bit flips
  localparam logic [1:0] DBUS_DBM = 2'h3;  // d bus takes the bus mux
  localparam logic [2:0] DBM_DP   = 3'h5;  // bus mux takes the datapath
  localparam logic [2:0] RAM_ABS  = 3'h7;  // absolute ram file reference
  // apb map and control reset values
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STAT   = 8'h04;
  localparam logic [7:0] A_SEQ    = 8'h08;
  localparam logic [1:0] CTRL_RST = 2'h1;  // run on, stop on error off

  typedef enum logic [1:0] {
    MWFD_EXEC   = 2'h0,  // cycle in progress
    MWFD_LAST   = 2'h1,  // final tick of the cycle
    MWFD_HALT   = 2'h3   // stopped by software or parity error
  } mwfd_state_t;

  // level controls that stand for a whole processor cycle
  typedef struct packed {
    logic [2:0]  alu_func;
    logic [2:0]  left_src;
    logic [2:0]  right_src;
    logic [2:0]  slice_dest;
    logic [3:0]  a_addr;
    logic [3:0]  b_addr;
    logic [2:0]  ram_src;
    logic [1:0]  dbus_src;
    logic [2:0]  mux_src;
    logic        clk_left;
    logic        clk_right;
    logic        carry_in;
    logic [2:0]  shift_link;
    logic        byte_ins;
    logic [2:0]  byte_pos;
    logic [17:0] number;
  } mwfd_ctl_t;

  // one-tick strobes raised in the final tick of a cycle
  typedef struct packed {
    logic [23:0] special;
    logic        rf_wr_left;
    logic        rf_wr_right;
    logic        ram_write;
    logic        mem_go;
    logic        push;
    logic        load_sc;
    logic        load_fe;
    logic        dp_clk;
    logic        mc_clk;
  } mwfd_stb_t;
endpackage : mwfd_pkg

// [hw/mwfd_decoder.sv]
// microword register, field decode, sequencing and register file parity
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
// Notes on behaviour
// [RL1] bits 0-11 give next address base
// [RL2] six-bit adder field: function and source
// [RL3] middle destination bit inverted to slices
// [RL4] right source defaults to left source
// [RL5] only B address selects written register
// [RL6] ram address source, absolute uses address low ten
// [RL7] d bus source and bus mux input
// [RL8] separate half clocks, unclocked half unchanged
// [RL9] store even parity and valid per half
// [RL10] per-half parity check against B register
// [RL11] check suppressed when stored valid clear
// [RL12] special: three group enables, shared low decode
// [RL13] low special bits: shift links, byte position
// [RL14] dispatch ORs into address bits 0-7, 8-11
// [RL15] any chosen skip condition sets bit 11
// [RL16] cycle is two ticks plus time field
// [RL17] carry injected into adder lsb
// [RL18] load step counter and shift count
// [RL19] write d bus into ram file
// [RL20] start memory or io operation
// [RL21] fast shift: no-op or repeat until overflow
// [RL22] push current location on subroutine call
// [RL23] repeat holds sequencer clock, datapath runs
// [RL24] load next word each non-repeated cycle
module mwfd_decoder
  import mwfd_pkg::*;
(
  input  wire logic              clk_sys,        // processor tick clock
  input  wire logic              rst,            // synchronous reset
  input  wire logic [0:MW_W-1]   cs_word,        // control store data at cs_addr_q
  input  wire logic [0:35]       dbus,           // d bus value from datapath
  input  wire logic [9:0]        memory_address_reg, // low bits of address reg
  input  wire logic [9:0]        scale_adder,    // scale adder output
  input  wire logic [17:0]       skip_conds,     // three sets of six conditions
  input  wire logic [8*12-1:0]   disp_src,       // eight dispatch quantities
  input  wire logic [8*4-1:0]    disp_alt,       // eight alternate low nibbles
  input  wire logic              psel,           // apb select
  input  wire logic              penable,        // apb enable
  input  wire logic              pwrite,         // apb direction
  input  wire logic [7:0]        paddr,          // apb byte address
  input  wire logic [31:0]       pwdata,         // apb write data
  output logic [31:0]            prdata,         // apb read data
  output logic                   pready,         // apb ready
  output logic                   pslverr,        // apb error on unmapped
  output logic [0:11]            cs_addr_q,      // next control store address
  output mwfd_ctl_t              ctl_q,          // decoded cycle controls
  output mwfd_stb_t              stb_q,          // final-tick strobes
  output logic [9:0]             ram_abs_q,      // absolute ram file address
  output logic [9:0]             fe_q,           // shift count register
  output logic [9:0]             sc_q            // step counter
);

  // even parity of one half word
  function automatic logic half_par(input logic [0:17] h);
    half_par = ^h;
  endfunction : half_par

  // one-hot decode of the shared low three bits, gated by a group enable
  function automatic logic [7:0] grp_dec(input logic en, input logic [2:0] sel);
    grp_dec = en ? (8'h01 << sel) : 8'h00;
  endfunction : grp_dec

  logic [0:MW_W-1] mw_q;            // microword register
  mwfd_state_t     st_q;            // cycle state
  logic [1:0]      tick_q;          // ticks done in this cycle
  logic [1:0]      ctrl_q;          // run, stop on parity error
  logic            perr_l_q;        // sticky left parity error
  logic            perr_r_q;        // sticky right parity error
  logic [1:0]      par_l_q [16];    // left {valid, parity} per register
  logic [1:0]      par_r_q [16];    // right {valid, parity} per register
  logic            run;             // sequencing allowed
  logic            hold;            // park now, at a cycle boundary
  logic            go_last;         // next tick is the final one
  logic            fast;            // fast shift requested
  logic            dp_go;           // datapath acts this cycle
  logic            mc_go;           // sequencer advances this cycle
  logic [0:11]     next_addr;       // assembled next address
  logic            skip_hit;        // some chosen skip condition true
  logic            chk_l;           // left check fires
  logic            chk_r;           // right check fires
  logic            err_l;           // left mismatch this final tick
  logic            err_r;           // right mismatch this final tick
  logic            apb_wr;          // write completes this edge
  mwfd_ctl_t       ctl_d;           // decode of the incoming word
  mwfd_stb_t       stb_d;           // strobes for the coming final tick

  // halting waits for a cycle boundary so a half-done cycle never freezes
  assign run      = ctrl_q[0] && !(ctrl_q[1] && (perr_l_q || perr_r_q));
  // a stop request mid-cycle lets the cycle run out first
  assign hold     = !run && (tick_q == 2'h0);
  // [RL16] two ticks plus extra
  assign go_last  = (st_q == MWFD_EXEC) && !hold && (tick_q == mw_q[F_TIME +: 2]);
  assign fast     = mw_q[F_FAST];
  // [RL21] fast shift gating
  assign dp_go    = !fast || fe_q[9];
  // [RL23] repeat holds sequencer
  assign mc_go    = !(fast && fe_q[9]);
  assign apb_wr   = psel && penable && pready && pwrite;

  // skip and dispatch assembly of the next address
  always_comb begin
    logic [2:0]  dsel;
    logic [2:0]  ssel;
    logic [0:11] dq;
    dsel = mw_q[F_DISP+3 +: 3];
    ssel = mw_q[F_SKIP+3 +: 3];
    dq   = disp_src[12*dsel +: 12];
    // [RL15] skip into bit 11
    skip_hit = 1'b0;
    for (int g = 0; g < 3; g++) begin
      if (mw_q[F_SKIP+g] && ssel < 3'h6) begin
        skip_hit = skip_hit | skip_conds[6*g + ssel];
      end
    end
    // [RL1] base address
    next_addr = mw_q[F_J +: 12];
    // [RL14] dispatch into high bits
    if (mw_q[F_DISP+1]) begin
      next_addr[0:7] = next_addr[0:7] | dq[0:7];
    end
    // [RL14] dispatch into low bits
    if (mw_q[F_DISP+2]) begin
      next_addr[8:11] = next_addr[8:11] | dq[8:11];
    end
    if (mw_q[F_DISP]) begin
      next_addr[8:11] = next_addr[8:11] | disp_alt[4*dsel +: 4];
    end
    next_addr[11] = next_addr[11] | skip_hit;
  end

  // decode of the word about to be loaded
  always_comb begin
    logic [2:0] dst;
    logic [2:0] sp;
    dst = cs_word[F_DEST +: 3];
    sp  = cs_word[F_SPEC+3 +: 3];
    // [RL2] function and source halves
    ctl_d.alu_func   = cs_word[F_ADFN +: 3];
    ctl_d.left_src   = cs_word[F_LEFT_SOURCE_SELECT +: 3];
    // [RL4] right defaults to left
    ctl_d.right_src  = cs_word[F_RSEL] ? cs_word[F_RIGHT_SOURCE_SELECT +: 3] : cs_word[F_LEFT_SOURCE_SELECT +: 3];
    // [RL3] invert middle bit
    ctl_d.slice_dest = dst ^ DEST_INV;
    ctl_d.a_addr     = cs_word[F_A +: 4];
    ctl_d.b_addr     = cs_word[F_B +: 4];
    // [RL6] ram address source
    ctl_d.ram_src    = cs_word[F_RAMSRC +: 3];
    // [RL7] d bus and mux sources
    ctl_d.dbus_src   = cs_word[F_DBUS +: 2];
    ctl_d.mux_src    = cs_word[F_DBM +: 3];
    // [RL8] half clocks
    ctl_d.clk_left   = cs_word[F_CLKL];
    ctl_d.clk_right  = cs_word[F_CLKR];
    // [RL17] carry into lsb
    ctl_d.carry_in   = cs_word[F_CRY];
    // [RL13] shift links when the slice shifts (codes 4-7)
    ctl_d.shift_link = ctl_d.slice_dest[2] ? sp : 3'h0;
    // [RL13] byte insertion when the d bus takes the bus mux and the bus mux takes the datapath
    ctl_d.byte_ins   = (ctl_d.dbus_src == DBUS_DBM) && (ctl_d.mux_src == DBM_DP);
    ctl_d.byte_pos   = ctl_d.byte_ins ? sp : 3'h0;
    ctl_d.number     = cs_word[F_NUM +: 18];
  end

  // strobes for the final tick of the current word
  always_comb begin
    logic [2:0] sp;
    logic       wr;
    sp = mw_q[F_SPEC+3 +: 3];
    // [RL5] only slice codes 2-7 write the file, at the B address
    wr = (ctl_q.slice_dest > 3'h1) && dp_go;
    // [RL12] group enables share one low decode
    stb_d.special     = {grp_dec(mw_q[F_SPEC], sp), grp_dec(mw_q[F_SPEC+1], sp),
                         grp_dec(mw_q[F_SPEC+2], sp)} & {24{dp_go}};
    // [RL8] an unclocked half never writes
    stb_d.rf_wr_left  = wr && ctl_q.clk_left;
    stb_d.rf_wr_right = wr && ctl_q.clk_right;
    // [RL19] ram file write
    stb_d.ram_write   = mw_q[F_RAMWR] && dp_go;
    // [RL20] memory or io start
    stb_d.mem_go      = mw_q[F_MEM] && dp_go;
    // [RL22] subroutine push
    stb_d.push        = mw_q[F_CALL] && mc_go;
    // [RL18] counter loads
    stb_d.load_sc     = mw_q[F_LDSC] && dp_go;
    stb_d.load_fe     = mw_q[F_LDFE] && dp_go;
    stb_d.dp_clk      = dp_go;
    stb_d.mc_clk      = mc_go;
  end

  // cycle state and tick count
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q   <= MWFD_EXEC;
      tick_q <= 2'h0;
    end else if (st_q == MWFD_LAST) begin
      st_q   <= MWFD_EXEC;
      tick_q <= 2'h0;
    end else if (hold) begin
      // parked at a cycle boundary, nothing half done
      st_q   <= MWFD_HALT;
    end else if (st_q == MWFD_HALT) begin
      // restart with a fresh first tick
      st_q   <= MWFD_EXEC;
      tick_q <= 2'h0;
    end else if (go_last) begin
      st_q   <= MWFD_LAST;
    end else begin
      st_q   <= MWFD_EXEC;
      tick_q <= tick_q + 2'h1;
    end
  end

  // strobes stand exactly for the final tick
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stb_q <= '0;
    end else begin
      stb_q <= go_last ? stb_d : '0;
    end
  end

  // next address is presented one tick before the word is taken
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cs_addr_q <= 12'h000;
    end else if (go_last && mc_go) begin
      cs_addr_q <= next_addr;
    end
  end

  // [RL24] word register loads at each non-repeated cycle end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // reset word decodes to the all-zero controls held in ctl_q
      mw_q  <= MW_W'(DEST_INV) << (MW_W - 3 - F_DEST);
      ctl_q <= '0;
    end else if (st_q == MWFD_LAST && stb_q.mc_clk) begin
      mw_q  <= cs_word;
      ctl_q <= ctl_d;
    end
  end

  // absolute ram file address follows the address register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ram_abs_q <= 10'h000;
    end else begin
      // [RL6] absolute uses low ten
      ram_abs_q <= memory_address_reg;
    end
  end

  // shift count: loaded from scale adder, stepped while repeating
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fe_q <= 10'h000;
    end else if (st_q == MWFD_LAST && stb_q.load_fe) begin
      // [RL18] load shift count
      fe_q <= scale_adder;
    end else if (st_q == MWFD_LAST && stb_q.dp_clk && fast) begin
      // [RL21] count toward overflow
      fe_q <= fe_q + 10'h001;
    end
  end

  // step counter load
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sc_q <= 10'h000;
    end else if (st_q == MWFD_LAST && stb_q.load_sc) begin
      // [RL18] load step counter
      sc_q <= scale_adder;
    end
  end

  // [RL9] parity and valid stored per half
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        par_l_q[i] <= 2'h0;
        par_r_q[i] <= 2'h0;
      end
    end else if (st_q == MWFD_LAST) begin
      if (stb_q.rf_wr_left) begin
        par_l_q[ctl_q.b_addr] <= {mw_q[F_LEFT_PARITY_VALID_GEN], half_par(dbus[0:17])};
      end
      if (stb_q.rf_wr_right) begin
        par_r_q[ctl_q.b_addr] <= {mw_q[F_RIGHT_PARITY_VALID_GEN], half_par(dbus[18:35])};
      end
    end
  end

  // [RL10] check against B register
  // [RL11] valid gates the check
  assign chk_l = mw_q[F_CHKL] && par_l_q[ctl_q.b_addr][1] && stb_q.dp_clk;
  assign chk_r = mw_q[F_CHKR] && par_r_q[ctl_q.b_addr][1] && stb_q.dp_clk;
  assign err_l = (st_q == MWFD_LAST) && chk_l &&
                 (half_par(dbus[0:17]) != par_l_q[ctl_q.b_addr][0]);
  assign err_r = (st_q == MWFD_LAST) && chk_r &&
                 (half_par(dbus[18:35]) != par_r_q[ctl_q.b_addr][0]);

  // sticky errors; a new error beats a clear in the same edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      perr_l_q <= 1'b0;
      perr_r_q <= 1'b0;
    end else begin
      perr_l_q <= err_l || (perr_l_q && !(apb_wr && paddr == A_STAT && pwdata[0]));
      perr_r_q <= err_r || (perr_r_q && !(apb_wr && paddr == A_STAT && pwdata[1]));
    end
  end

  // control register write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
    end else if (apb_wr && paddr == A_CTRL) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  // apb answer: ready one cycle after setup, unmapped gives an error
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready &&
                 !(paddr == A_CTRL || paddr == A_STAT || paddr == A_SEQ);
      case (paddr)
        A_CTRL:  prdata <= {30'h0, ctrl_q};
        A_STAT:  prdata <= {29'h0, !run, perr_r_q, perr_l_q};
        A_SEQ:   prdata <= {10'h0, fe_q, cs_addr_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // checks
  logic [2:0] hcnt_q;  // ticks since the last cycle end
  always_ff @(posedge clk_sys) begin
    if (rst || st_q == MWFD_LAST || st_q == MWFD_HALT) begin
      hcnt_q <= 3'h0;
    end else begin
      hcnt_q <= hcnt_q + 3'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_cycle_len: assert property (st_q == MWFD_LAST |-> hcnt_q == 3'(mw_q[F_TIME +: 2]) + 3'h1)
    else $error("cycle length wrong"); // [RL16]
  chk_dest_map: assert property (ctl_q.slice_dest == (mw_q[F_DEST +: 3] ^ 3'h2))
    else $error("destination map wrong"); // [RL3]
  chk_right_source_select_dflt: assert property (!mw_q[F_RSEL] |-> ctl_q.right_src == ctl_q.left_src)
    else $error("right source default wrong"); // [RL4]
  chk_fast_noop: assert property (stb_q.dp_clk |-> !(fast && !fe_q[9]))
    else $error("fast shift no-op ran datapath"); // [RL21]
  chk_repeat_hold: assert property (st_q == MWFD_LAST && !stb_q.mc_clk |=> $stable(mw_q))
    else $error("repeat changed microword"); // [RL23]
  chk_skip_bit: assert property (go_last && mc_go && skip_hit |=> cs_addr_q[11])
    else $error("skip not in bit 11"); // [RL15]
  chk_half_clock: assert property (stb_q.rf_wr_left |-> ctl_q.clk_left && stb_q.dp_clk)
    else $error("unclocked half written"); // [RL8]
  chk_push_seq: assert property (stb_q.push |-> st_q == MWFD_LAST && stb_q.mc_clk)
    else $error("push outside advancing cycle end"); // [RL22]
  chk_valid_gate: assert property ($rose(perr_l_q) |-> $past(par_l_q[ctl_q.b_addr][1]))
    else $error("check without valid"); // [RL11]
  chk_word_load: assert property (st_q == MWFD_LAST && stb_q.mc_clk |=> mw_q == $past(cs_word))
    else $error("word not loaded"); // [RL24]

endmodule : mwfd_decoder

// [verification/mwfd_cs_model.sv]
// control store model that feeds microwords back to the decoder
`timescale 1ns/1ns
module mwfd_cs_model
  import mwfd_pkg::*;
(
  input  wire logic [0:11]     cs_addr, // address from the decoder
  output logic      [0:MW_W-1] cs_word  // word held at that address
);
  // word store, loaded by the bench; unwritten words read as zero
  logic [0:MW_W-1] mem [4096] = '{default: '0};
  // plain asynchronous read: word is settled long before the next tick
  assign cs_word = mem[cs_addr];
endmodule : mwfd_cs_model

// [verification/mwfd_decoder_tb_top.sv]
// self-checking bench for the microword field decoder
`timescale 1ns/1ns
module mwfd_decoder_tb_top;
  import mwfd_pkg::*;
  // one ordinary microword: coded fields and what the decode should give
  typedef struct {
    logic [2:0] dest, left_source_select, right_source_select, adfn;
    logic       rsel;  // right source coded
    logic [4:0] act;   // carry, step load, shift load, ram write, mem
    logic [2:0] xs, xr; // expected slice dest and right source
  } mwfd_row_t;
  mwfd_row_t rows [8] = '{
    '{3'h0, 3'h1, 3'h0, 3'h5, 1'h0, 5'h12, 3'h2, 3'h1},
    '{3'h1, 3'h2, 3'h6, 3'h0, 1'h1, 5'h01, 3'h3, 3'h6},
    '{3'h2, 3'h3, 3'h0, 3'h7, 1'h0, 5'h08, 3'h0, 3'h3},
    '{3'h3, 3'h4, 3'h1, 3'h1, 1'h1, 5'h04, 3'h1, 3'h1},
    '{3'h4, 3'h5, 3'h0, 3'h2, 1'h0, 5'h00, 3'h6, 3'h5},
    '{3'h5, 3'h6, 3'h2, 3'h3, 1'h1, 5'h1F, 3'h7, 3'h2},
    '{3'h6, 3'h7, 3'h0, 3'h4, 1'h0, 5'h00, 3'h4, 3'h7},
    '{3'h7, 3'h0, 3'h5, 3'h6, 1'h1, 5'h00, 3'h5, 3'h5}};
  logic            clk_sys = 1'h0;   // tick clock
  logic            rst     = 1'h1;   // sync reset
  logic [0:35]     dbus    = '0;     // d bus from datapath side
  logic            psel    = 1'h0;   // apb select
  logic            penable = 1'h0;   // apb enable
  logic            pwrite  = 1'h0;   // apb direction
  logic [7:0]      paddr   = 8'h00;  // apb address
  logic [31:0]     pwdata  = 32'h0;  // apb write data
  logic [31:0]     prdata, rd;       // read data, last taken
  logic            pready, pslverr, er;
  logic [0:11]     cs_addr_q;        // next address
  logic [0:MW_W-1] cs_word, w;       // fetched word, word builder
  mwfd_ctl_t       ctl_q;            // cycle controls
  mwfd_stb_t       stb_q;            // final-tick strobes
  logic [9:0]      ram_abs_q, fe_q, sc_q;
  int              n_errors = 0, n_compared = 0, cyc = 0, last = 0, gap, npul = 0, n;

  mwfd_cs_model i_mwfd_cs_model (.cs_addr(cs_addr_q), .cs_word(cs_word));
  // skip condition 2 of set 0 true; dispatch quantity 3 is A5C
  mwfd_decoder i_mwfd_decoder (.clk_sys(clk_sys), .rst(rst), .cs_word(cs_word),
    .dbus(dbus), .memory_address_reg(10'h155), .scale_adder(10'h3FE),
    .skip_conds(18'h00004), .disp_src(96'h000000000000A5C000000000),
    .disp_alt(32'h0), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cs_addr_q(cs_addr_q), .ctl_q(ctl_q), .stb_q(stb_q),
    .ram_abs_q(ram_abs_q), .fe_q(fe_q), .sc_q(sc_q));

  always #2 clk_sys = ~clk_sys;
  // tick count, final-tick count and hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (stb_q.dp_clk | stb_q.mc_clk)
      npul <= npul + 1;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // place a field with its first bit as msb
  function automatic logic [0:MW_W-1] put(input logic [0:MW_W-1] v, input int p,
                                          input int k, input logic [17:0] x);
    for (int i = 0; i < k; i++)
      v[p+i] = x[k-1-i];
    return v;
  endfunction : put

  // wait for the final tick of the running cycle, bounded
  task automatic fin();
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      #1;
      k++;
    end while (!(stb_q.dp_clk === 1'h1 || stb_q.mc_clk === 1'h1) && k < 50);
    gap = cyc - last;
    last = cyc;
    if (k >= 50)
      n_errors++;
  endtask : fin

  // edge that loads the next word; d bus for that cycle set with it
  task automatic ld(input logic [0:35] d);
    @(posedge clk_sys);
    dbus <= d;
    #1;
  endtask : ld

  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    // no cycle count assumed; the hang guard ends a stuck wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  initial begin
    // straight-line words 0..7 from the table
    for (int i = 0; i < 8; i++) begin
      w = put(put(put('0, F_J, 12, 18'(i + 1)), F_ADFN, 3, rows[i].adfn), F_LEFT_SOURCE_SELECT, 3, rows[i].left_source_select);
      w = put(put(put(w, F_DEST, 3, rows[i].dest), F_RIGHT_SOURCE_SELECT, 3, rows[i].right_source_select), F_CRY, 5, rows[i].act);
      w = put(put(w, F_A, 4, 18'(i)), F_B, 4, 18'(15 - i));
      w[F_RSEL] = rows[i].rsel;
      i_mwfd_cs_model.mem[i] = w;
    end
    // skip, call, all special groups, shifting destination
    w = put(put(put('0, F_J, 12, 12'h010), F_SKIP, 6, 6'h22), F_SPEC, 6, 6'h3D);
    w = put(put(w, F_DEST, 3, 3'h4), F_NUM, 18, 18'h2ABCD);
    w[F_CALL] = 1'h1;
    i_mwfd_cs_model.mem[8] = w;
    // zero jump field, dispatch on left eight bits, byte insert
    w = put(put(put('0, F_DISP, 6, 6'h13), F_DBUS, 2, 2'h3), F_DBM, 3, 3'h5);
    w = put(w, F_SPEC, 6, 6'h06);
    i_mwfd_cs_model.mem[12'h011] = w;
    // file write at B 5, left valid, right not, two extra ticks
    w = put(put(put('0, F_J, 12, 12'hA51), F_B, 4, 4'h5), F_TIME, 2, 2'h2);
    w[F_CLKL] = 1'h1;
    w[F_LEFT_PARITY_VALID_GEN] = 1'h1;
    w[F_CLKR] = 1'h1;
    i_mwfd_cs_model.mem[12'hA50] = w;
    // both checks against B 5, no file write, absolute ram address
    w = put(put(put(put('0, F_J, 12, 12'hA52), F_DEST, 3, 3'h3), F_B, 4, 4'h5), F_RAMSRC, 3, 3'h7);
    w[F_CHKL] = 1'h1;
    w[F_CHKR] = 1'h1;
    i_mwfd_cs_model.mem[12'hA51] = w;
    // fast shift twice, second with the count already spent
    for (int i = 0; i < 2; i++) begin
      w = put('0, F_J, 12, 18'(12'hA53 + i));
      w[F_FAST] = 1'h1;
      w[F_RAMWR] = 1'h1;
      i_mwfd_cs_model.mem[12'hA52 + i] = w;
    end
    i_mwfd_cs_model.mem[12'hA54] = put('0, F_J, 12, 12'hA54);
    repeat (20) @(posedge clk_sys);
    #1;
    chk(32'(stb_q === '0 && ctl_q === '0 && cs_addr_q === '0), 1);
    @(posedge clk_sys);
    rst <= 1'h0;
    fin();
    chk(cs_addr_q, 12'h000);
    for (int i = 0; i < 8; i++) begin
      ld(36'h0);
      chk(ctl_q.slice_dest, rows[i].xs);
      chk(ctl_q.right_src, rows[i].xr);
      chk({ctl_q.alu_func, ctl_q.left_src}, {rows[i].adfn, rows[i].left_source_select});
      chk({ctl_q.a_addr, ctl_q.b_addr}, 8'(i * 15 + 15));
      chk(ctl_q.carry_in, rows[i].act[4]);
      fin();
      chk({stb_q.load_sc, stb_q.load_fe, stb_q.ram_write, stb_q.mem_go},
          rows[i].act[3:0]);
      chk(cs_addr_q, i + 1);
      chk(gap, 2);
    end
    chk({sc_q, fe_q}, 20'hFFBFE);
    ld(36'h0);
    chk(ctl_q.shift_link, 3'h5);
    chk(ctl_q.number, 18'h2ABCD);
    fin();
    chk(stb_q.special, 24'h202020);
    chk(stb_q.push, 1);
    chk(cs_addr_q, 12'h011);
    ld(36'h0);
    chk({ctl_q.byte_ins, ctl_q.byte_pos}, 4'hE);
    chk({ctl_q.dbus_src, ctl_q.mux_src}, 5'h1D);
    fin();
    chk(cs_addr_q, 12'hA50);
    fin();
    chk(gap, 4);
    chk({stb_q.rf_wr_left, stb_q.rf_wr_right}, 2'h3);
    ld(36'h000040001);
    chk(ctl_q.ram_src, 3'h7);
    chk(ram_abs_q, 10'h155);
    fin();
    chk({stb_q.rf_wr_left, stb_q.rf_wr_right}, 2'h0);
    for (int k = 0; k < 3; k++) begin
      fin();
      chk({stb_q.mc_clk, stb_q.dp_clk}, (k == 2) ? 2'h2 : 2'h1);
      chk(cs_addr_q, (k == 2) ? 12'hA53 : 12'hA52);
    end
    chk({fe_q, stb_q.ram_write}, 11'h000);
    fin();
    chk({stb_q.mc_clk, stb_q.dp_clk, stb_q.ram_write}, 3'h4);
    chk(cs_addr_q, 12'hA54);
    apb(1'h0, A_STAT, 32'h0);
    chk(rd, 32'h1);
    apb(1'h1, A_STAT, 32'h3);
    apb(1'h0, A_STAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, A_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'h0, 8'h0C, 32'h0);
    chk(er, 1'h1);
    chk(rd, 32'h0);
    apb(1'h0, A_SEQ, 32'h0);
    chk(rd, 32'h00000A54);
    // stopped sequencer must raise no further final ticks
    apb(1'h1, A_CTRL, 32'h0);
    repeat (6) @(posedge clk_sys);
    n = npul;
    repeat (12) @(posedge clk_sys);
    chk(npul - n, 0);
    apb(1'h0, A_STAT, 32'h0);
    chk(rd, 32'h4);
    apb(1'h1, A_CTRL, 32'h1);
    fin();
    chk(cs_addr_q, 12'hA54);
    report_and_stop();
  end
endmodule : mwfd_decoder_tb_top
